/* File: inc/sdf_pkg.sv */
// Purpose: constants and carrier types for the sinc decimation filter
// Assumes: one clock mclk, synchronous active-high reset
// Notes:   control bits are plain ports; no register bus
// Contract
// [R01] offset code is a sign bit plus a 3-bit magnitude to the DAC
// [R02] one magnitude step is 16.7 percent unipolar, 8.3 percent bipolar
// [R03] zero offset code disconnects the DAC entirely
// [R04] clock select low means 1.024MHz, high means 2.4576MHz, high after reset
// [R05] standby stops everything except serial side and oscillator
// [R06] full power down stops the whole device including oscillator
// [R07] host waits for the clock then resets after full power down
// [R08] double-clock bit divides the master clock by two, 50 percent duty
// [R09] decimate the 1-bit stream by sinc1 or sinc3, sinc3 default
// [R10] sinc1 settles in one word period, sinc3 in three
// [R11] fast bit set selects sinc1, cleared selects sinc3
// [R12] clearing fast drops ready until three word periods have passed
// [R13] modulator-output bit set bypasses the filter to the serial output
// [R14] sinc3 equals three cascaded moving sums of length N, each over N
// [R15] N is modulator rate over word rate, one word per N bits
// [R16] word rate sits on the first notch; cutoff is 0.262 of it
// [R17] clock, prescale, rate and notch fields set N and the notch
// [R18] synchronised step settles in three periods, unsynchronised up to four
// [R19] ready rises on each new word latched and falls when it is read
package sdf_pkg;
  localparam int          SDF_SINC3_SETTLE = 3;   // word periods
  localparam int          SDF_SINC1_SETTLE = 1;   // word periods
  localparam int          SDF_DAC_MAG_W    = 3;
  localparam logic [2:0]  SDF_DAC_OFF      = 3'h0;
  // offset steps in tenths of a percent of range
  localparam logic [7:0]  SDF_STEP_UNI     = 8'hA7;  // 16.7 %
  localparam logic [7:0]  SDF_STEP_BIP     = 8'h53;  // 8.3 %
  localparam logic        SDF_CLK_SEL_RST  = 1'b1;
  // base decimation factors indexed by notch select, at slowest rate
  localparam logic [15:0] SDF_N_BASE_0     = 16'h0180; // clk=1 fs=0
  localparam logic [15:0] SDF_N_BASE_1     = 16'h0140; // clk=1 fs=1
  localparam logic [15:0] SDF_N_BASE_2     = 16'h0040;
  localparam logic [15:0] SDF_N_BASE_3     = 16'h0020;
  localparam logic [15:0] SDF_N_CLK0_0     = 16'h0190; // clk=0 fs=0
  localparam logic [15:0] SDF_N_CLK0_1     = 16'h0140;

  typedef struct packed {
    logic       clock_select;        // 1 = 2.4576MHz
    logic       prescale_half_enable;
    logic       modulator_rate_bit_hi;
    logic       modulator_rate_bit_lo;
    logic       notch_select_bit_hi;
    logic       notch_select_bit_lo;
    logic       fast_settle;
    logic       raw_modulator_output_enable;
  } sdf_setup_type;

  typedef struct packed {
    logic       connect;
    logic       sign;
    logic [2:0] magnitude;
    logic [7:0] step_permille;       // shift per step, tenths of a percent
  } sdf_dac_type;
endpackage : sdf_pkg

/* File: rtl/sdf_prescale.sv */
// Purpose: optional divide-by-two of the master clock as a tick
// Assumes: mclk stands for the oscillator; output is an enable tick
// Notes:   tick every edge when bypassed, every second when halving
`timescale 1ns/100ps
`default_nettype none
module sdf_prescale
  import sdf_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic run,
  input  wire logic prescale_half_enable,
  output logic      tick
);
  logic phase_reg;

  // toggling phase gives an even 50 percent internal clock
  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg; // R08
    end
  end

  assign tick = run && (!prescale_half_enable || phase_reg); // R08
endmodule : sdf_prescale
`default_nettype wire

/* File: rtl/sdf_moving_sum.sv */
// Purpose: one sinc stage as integrator over the block plus dump
// Assumes: in_valid marks each input sample
// Notes:   comb is done by restarting the sum at each block boundary
`timescale 1ns/100ps
`default_nettype none
module sdf_moving_sum
  import sdf_pkg::*;
#(
  parameter int W = 40
)
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         clear,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic [W-1:0]      acc
);
  // elaboration check: the stage sum needs room to grow
  if (W < 8) begin : g_bad_width
    $error("sdf_moving_sum: width too small");
  end

  // running sum of the stage input
  always_ff @(posedge mclk) begin
    if (reset || clear) begin
      acc <= '0;
    end else if (in_valid) begin
      acc <= acc + in_data; // R14
    end
  end
endmodule : sdf_moving_sum
`default_nettype wire

/* File: rtl/sdf_filter.sv */
// Purpose: sinc1/sinc3 decimator, bypass, power and offset DAC control
// Assumes: all inputs synchronous to mclk; modulator bit valid per tick
// Notes:   sinc3 built as three cascaded integrate-and-dump stages of N
`timescale 1ns/100ps
`default_nettype none
module sdf_filter
  import sdf_pkg::*;
#(
  parameter int OUT_W = 24,
  parameter int ACC_W = 40
)
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire sdf_setup_type    setup,
  input  wire logic             standby_request,
  input  wire logic             full_power_down,
  input  wire logic             filter_sync_hold,
  input  wire logic             bipolar,
  input  wire logic             dac_sign,
  input  wire logic [2:0]       dac_magnitude,
  input  wire logic             modulator_bit,
  input  wire logic             result_read,
  output logic [OUT_W-1:0]      result_data,
  output logic                  result_ready_flag,
  output logic                  serial_data_out,
  output sdf_dac_type           dac_ctrl,
  output logic                  analog_enable,
  output logic                  oscillator_enable,
  output logic                  clock_select_out,
  output logic [15:0]           decimation_n
);
  // elaboration check: the word must fit inside the accumulators
  if (OUT_W > ACC_W || ACC_W < 32) begin : g_bad_width
    $error("sdf_filter: bad widths");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FILL  = 3'b010,
    ST_VALID = 3'b100
  } sdf_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // decimation factor from clock, rate and notch fields
  function automatic logic [15:0] calc_n(input sdf_setup_type s);
    logic [15:0] base;
    base = 16'h0000;
    case ({s.notch_select_bit_hi, s.notch_select_bit_lo})
      2'h0:    base = s.clock_select ? SDF_N_BASE_0 : SDF_N_CLK0_0;
      2'h1:    base = s.clock_select ? SDF_N_BASE_1 : SDF_N_CLK0_1;
      2'h2:    base = SDF_N_BASE_2;
      default: base = SDF_N_BASE_3;
    endcase
    // faster modulator rate keeps notch, so N doubles with each step of the rate code
    calc_n = base << {s.modulator_rate_bit_hi, s.modulator_rate_bit_lo};
  endfunction : calc_n

  logic [15:0]      n_cur;
  logic             run;
  logic             tick;
  logic             bit_valid;
  logic [15:0]      cnt_reg;
  logic             boundary;
  logic [ACC_W-1:0] s1;
  logic [ACC_W-1:0] s2;
  logic [ACC_W-1:0] s3;
  logic [ACC_W-1:0] hold1_reg;
  logic [ACC_W-1:0] hold2_reg;
  logic [1:0]       settle_reg;
  logic [1:0]       settle_need;
  logic             fast_reg;
  logic [15:0]      n_reg;
  logic             clk_sel_reg;
  sdf_state_type    state_reg;
  sdf_state_type    state_next;

  assign n_cur = calc_n(setup); // R17
  assign decimation_n = n_reg;  // R15
  assign clock_select_out = clk_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock select default high, follows setup afterwards
  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_sel_reg <= SDF_CLK_SEL_RST; // R04
    end else begin
      clk_sel_reg <= setup.clock_select; // R04
    end
  end

  // power control outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      analog_enable     <= 1'b0;
      oscillator_enable <= 1'b1;
    end else begin
      analog_enable     <= !standby_request && !full_power_down; // R05 R06
      oscillator_enable <= !full_power_down; // R06
    end
  end

  // filter runs only when out of reset, powered and not in standby; sync hold leaves run high but gates bit_valid and clears the sums
  assign run = !reset && !standby_request && !full_power_down; // R05 R06

  sdf_prescale u_pre (
    .mclk                 (mclk),
    .reset                (reset),
    .run                  (run),
    .prescale_half_enable (setup.prescale_half_enable),
    .tick                 (tick)
  );

  assign bit_valid = tick && !filter_sync_hold;

  ////////////////////////////////////////////////////////////////////////////
  // offset DAC: zero magnitude disconnects the DAC
  always_ff @(posedge mclk) begin
    if (reset) begin
      dac_ctrl <= '0;
    end else begin
      dac_ctrl.connect       <= (dac_magnitude != SDF_DAC_OFF); // R03
      dac_ctrl.sign          <= dac_sign;                       // R01
      dac_ctrl.magnitude     <= dac_magnitude;                  // R01
      dac_ctrl.step_permille <= bipolar ? SDF_STEP_BIP
                                        : SDF_STEP_UNI;         // R02
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample counter over one word period of N bits
  always_ff @(posedge mclk) begin
    if (reset || filter_sync_hold || n_cur != n_reg) begin
      cnt_reg <= 16'h0000;
    end else if (bit_valid) begin
      cnt_reg <= boundary ? 16'h0000 : cnt_reg + 16'h0001; // R15
    end
  end

  assign boundary = bit_valid && (cnt_reg == n_reg - 16'h0001); // R15

  always_ff @(posedge mclk) begin
    if (reset) begin
      n_reg <= SDF_N_BASE_0;
    end else begin
      n_reg <= n_cur; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three cascaded block sums; each stage passes its dump to the next
  logic [ACC_W-1:0] in1;
  assign in1 = {{(ACC_W-1){1'b0}}, modulator_bit}; // R09

  sdf_moving_sum #(.W(ACC_W)) u_s1 (
    .mclk     (mclk),
    .reset    (reset),
    .clear    (boundary || filter_sync_hold),
    .in_valid (bit_valid),
    .in_data  (in1),
    .acc      (s1)
  );

  // each stage output re-enters the next for N bits: a moving sum of N
  always_ff @(posedge mclk) begin
    if (reset || filter_sync_hold) begin
      hold1_reg <= '0;
      hold2_reg <= '0;
    end else if (boundary) begin
      hold1_reg <= s1 + in1;  // R14
      hold2_reg <= s2 + hold1_reg; // R14
    end
  end

  sdf_moving_sum #(.W(ACC_W)) u_s2 (
    .mclk     (mclk),
    .reset    (reset),
    .clear    (boundary || filter_sync_hold),
    .in_valid (bit_valid),
    .in_data  (hold1_reg),
    .acc      (s2)
  );

  sdf_moving_sum #(.W(ACC_W)) u_s3 (
    .mclk     (mclk),
    .reset    (reset),
    .clear    (boundary || filter_sync_hold),
    .in_valid (bit_valid),
    .in_data  (hold2_reg),
    .acc      (s3)
  );

  ////////////////////////////////////////////////////////////////////////////
  // settling: word periods until the first valid word after sync, hold or sinc1 -> sinc3
  assign settle_need = setup.fast_settle ? 2'(SDF_SINC1_SETTLE)
                                         : 2'(SDF_SINC3_SETTLE); // R10 R11

  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= setup.fast_settle;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || filter_sync_hold || n_cur != n_reg
        || (fast_reg && !setup.fast_settle)) begin
      settle_reg <= 2'h0; // R12 R18
    end else if (boundary && settle_reg < settle_need) begin
      settle_reg <= settle_reg + 2'h1; // R10 R18
    end
  end

  // state: idle while stopped, fill while settling, valid afterwards
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (run) state_next = ST_FILL;
      ST_FILL:  begin
        if (!run) state_next = ST_IDLE;
        else if (boundary && settle_reg + 2'h1 >= settle_need)
          state_next = ST_VALID; // R10 R12
      end
      ST_VALID: begin
        if (!run) state_next = ST_IDLE;
        else if (filter_sync_hold || n_cur != n_reg
                 || (fast_reg && !setup.fast_settle))
          state_next = ST_FILL; // R12
      end
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output word latch; sinc1 uses the first stage, sinc3 the third
  logic [ACC_W-1:0] word_raw;
  assign word_raw = setup.fast_settle ? (s1 + in1)
                                      : (s3 + hold2_reg); // R09 R11

  always_ff @(posedge mclk) begin
    if (reset) begin
      result_data <= '0;
    end else if (boundary && state_next == ST_VALID) begin
      result_data <= word_raw[OUT_W-1:0]; // R14 R16
    end
  end

  // ready: set on a new word, cleared by read or loss of valid data
  always_ff @(posedge mclk) begin
    if (reset) begin
      result_ready_flag <= 1'b0;
    end else if (boundary && state_next == ST_VALID) begin
      result_ready_flag <= 1'b1; // R19
    end else if (result_read || state_next != ST_VALID) begin
      result_ready_flag <= 1'b0; // R12 R19
    end
  end

  // serial data: raw modulator bit in bypass, else msb of result
  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_data_out <= 1'b0;
    end else if (setup.raw_modulator_output_enable) begin
      serial_data_out <= modulator_bit; // R13
    end else begin
      serial_data_out <= result_data[OUT_W-1];
    end
  end
endmodule : sdf_filter
`default_nettype wire

/* File: tb/sdf_filter_properties.sv */
// Purpose: port assertions for sdf_filter
// Assumes: one clock, sync reset
// Notes:   bound onto every sdf_filter
`timescale 1ns/100ps
`default_nettype none
module sdf_filter_properties
  import sdf_pkg::*;
(
  input wire logic          mclk,
  input wire logic          reset,
  input wire sdf_setup_type setup,
  input wire logic          standby_request,
  input wire logic          full_power_down,
  input wire logic          filter_sync_hold,
  input wire logic          bipolar,
  input wire logic          dac_sign,
  input wire logic [2:0]    dac_magnitude,
  input wire logic          modulator_bit,
  input wire logic          result_read,
  input wire logic          result_ready_flag,
  input wire logic          serial_data_out,
  input wire sdf_dac_type   dac_ctrl,
  input wire logic          analog_enable,
  input wire logic          oscillator_enable,
  input wire logic          clock_select_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // two edges of hold or standby in a row
  sequence hold_on;
    filter_sync_hold ##1 filter_sync_hold;
  endsequence
  sequence standby_request_on;
    standby_request ##1 standby_request;
  endsequence
  ////////////////////////////////////////
  // offset dac and clock select mirror their inputs one edge later
  dac_code_a: assert property (1 |=> dac_ctrl.sign == $past(dac_sign)
    && dac_ctrl.magnitude == $past(dac_magnitude)) else $error("dac code");
  dac_off_a: assert property (1 |=> dac_ctrl.connect ==
    ($past(dac_magnitude) != SDF_DAC_OFF)) else $error("dac connect");
  dac_step_a: assert property (1 |=> dac_ctrl.step_permille ==
    ($past(bipolar) ? SDF_STEP_BIP : SDF_STEP_UNI)) else $error("dac step");
  clock_sel_a: assert property (1 |=>
    clock_select_out == $past(setup.clock_select)) else $error("clk sel");
  // power states
  standby_off_a: assert property (standby_request |=>
    !analog_enable) else $error("standby");
  power_down_a: assert property (full_power_down |=>
    !oscillator_enable && !analog_enable) else $error("power down");
  // bitstream bypass and ready handshake
  bypass_out_a: assert property (setup.raw_modulator_output_enable |=>
    serial_data_out == $past(modulator_bit)) else $error("bypass");
  read_clear_a: assert property (result_ready_flag && result_read |=>
    !result_ready_flag) else $error("read clear");
  hold_refuse_a: assert property (hold_on |->
    !$rose(result_ready_flag)) else $error("hold word");
  standby_request_refuse_a: assert property (standby_request_on |->
    !$rose(result_ready_flag)) else $error("standby word");
  fast_drop_a: assert property ($fell(setup.fast_settle) |->
    ##[1:2] !result_ready_flag) else $error("sinc3 ready");
endmodule : sdf_filter_properties
bind sdf_filter sdf_filter_properties sdf_filter_properties_inst (.mclk,
  .reset, .setup, .standby_request, .full_power_down, .filter_sync_hold,
  .bipolar, .dac_sign, .dac_magnitude, .modulator_bit, .result_read,
  .result_ready_flag, .serial_data_out, .dac_ctrl, .analog_enable,
  .oscillator_enable, .clock_select_out);
`default_nettype wire

/* File: tb/sdf_host_model.sv */
// Purpose: modulator and host stand-in for sdf_filter
// Assumes: host reads each flagged word once
// Notes:   bitstream is three ones then a zero
`timescale 1ns/100ps
`default_nettype none
module sdf_host_model
  import sdf_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic auto_read,
  input  wire logic result_ready_flag,
  output logic      modulator_bit,
  output logic      result_read
);
  logic [1:0] phase_reg = 2'h0;
  logic       read_reg  = 1'b0;
  // fixed density 1-bit stream, new bit every edge
  always @(posedge mclk) begin
    phase_reg <= phase_reg + 2'h1;
  end
  assign modulator_bit = (phase_reg != 2'h3);
  // one read pulse per flagged word
  always @(posedge mclk) begin
    read_reg <= !reset && auto_read && result_ready_flag && !read_reg;
  end
  assign result_read = read_reg;
endmodule : sdf_host_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for sdf_filter
// Assumes: fastest notch, full clock rate
// Notes:   word periods measured from ready rises
`timescale 1ns/100ps
`default_nettype none
module tb
  import sdf_pkg::*;
;
  logic          mclk  = 1'b0;
  logic          reset = 1'b1;
  sdf_setup_type setup;
  logic          standby_request, full_power_down, filter_sync_hold;
  logic          bipolar, dac_sign, auto_read, modulator_bit;
  logic [2:0]    dac_magnitude;
  logic          result_read, result_ready_flag, serial_data_out;
  logic          analog_enable, oscillator_enable, clock_select_out;
  logic [23:0]   result_data;
  logic [15:0]   decimation_n;
  sdf_dac_type   dac_ctrl;
  int            num_errors = 0;
  int            n_compared = 0;
  int            p, t1, t3;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  sdf_filter sdf_filter_inst (.mclk, .reset, .setup, .standby_request,
    .full_power_down, .filter_sync_hold, .bipolar, .dac_sign,
    .dac_magnitude, .modulator_bit, .result_read, .result_data,
    .result_ready_flag, .serial_data_out, .dac_ctrl, .analog_enable,
    .oscillator_enable, .clock_select_out, .decimation_n);
  sdf_host_model sdf_host_model_inst (.mclk, .reset, .auto_read,
    .result_ready_flag, .modulator_bit, .result_read);
  ////////////////////////////////////////
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("Error %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : chk
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // cycles until the next rise of ready, bounded
  task automatic to_rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = result_ready_flag;
      step();
      n++;
    end while (!(result_ready_flag === 1'b1 && prev !== 1'b1) && n < 9000);
    if (n >= 9000) begin
      num_errors++;
      $display("Error %0t: no word", $time);
      print_verdict();
    end
  endtask : to_rise
  ////////////////////////////////////////
  task automatic t_dac();
    sdf_dac_type want;
    for (int i = 0; i < 32; i++) begin
      {bipolar, dac_sign, dac_magnitude} = i[4:0];
      step();
      want = '{i[2:0] != 3'h0, i[3], i[2:0],
               i[4] ? SDF_STEP_BIP : SDF_STEP_UNI};
      chk(dac_ctrl, want);
    end
  endtask : t_dac
  task automatic t_power();
    standby_request = 1'b1;
    repeat (100) step();
    chk(analog_enable, 1'b0);
    chk(oscillator_enable, 1'b1);
    standby_request = 1'b0;
    full_power_down = 1'b1;
    repeat (2) step();
    chk(oscillator_enable, 1'b0);
    full_power_down = 1'b0;
    reset = 1'b1;
    repeat (2) step();
    reset = 1'b0;
    step();
    chk(analog_enable & oscillator_enable, 1'b1);
  endtask : t_power
  task automatic t_bypass();
    logic m;
    setup.raw_modulator_output_enable = 1'b1;
    step();
    repeat (8) begin
      m = modulator_bit;
      step();
      chk(serial_data_out, m);
    end
    setup.raw_modulator_output_enable = 1'b0;
  endtask : t_bypass
  task automatic t_rate();
    int q;
    to_rise(q);
    to_rise(p);
    chk(p, 32'(SDF_N_BASE_3));
    chk(decimation_n, SDF_N_BASE_3);
    setup.notch_select_bit_lo = 1'b0;
    to_rise(q);
    to_rise(q);
    chk(q, 2 * p);
    setup.notch_select_bit_lo = 1'b1;
    setup.prescale_half_enable = 1'b1;
    to_rise(q);
    to_rise(q);
    chk(q, 2 * p);
    setup.prescale_half_enable = 1'b0;
  endtask : t_rate
  task automatic t_settle();
    filter_sync_hold = 1'b1;
    setup.fast_settle = 1'b1;
    repeat (4) step();
    filter_sync_hold = 1'b0;
    to_rise(t1);
    // sinc1 word: N bits of a three-in-four stream sum to 24
    chk(result_data, 24'h000018);
    filter_sync_hold = 1'b1;
    setup.fast_settle = 1'b0;
    repeat (4) step();
    filter_sync_hold = 1'b0;
    to_rise(t3);
    chk(t3 - t1, 2 * p);
    // live switch back to sinc3 with ready left standing
    setup.fast_settle = 1'b1;
    repeat (4) step();
    auto_read = 1'b0;
    to_rise(t1);
    setup.fast_settle = 1'b0;
    repeat (2) step();
    chk(result_ready_flag, 1'b0);
    to_rise(t3);
    chk(t3 + 2 >= 3 * p, 1'b1);
    auto_read = 1'b1;
  endtask : t_settle
  ////////////////////////////////////////
  // main sequence
  initial begin
    {standby_request, full_power_down, filter_sync_hold} = 3'h0;
    {bipolar, dac_sign, dac_magnitude} = 5'h00;
    auto_read = 1'b1;
    setup = 8'h8C;
    repeat (2) @(posedge mclk);
    #1;
    chk(clock_select_out, 1'b1);
    chk(oscillator_enable, 1'b1);
    reset = 1'b0;
    t_dac();
    t_power();
    t_bypass();
    t_rate();
    t_settle();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
